// ==== rtl/cdw_consts.svh ====
/*
 * Constants of the countdown watchdog: register indices, field positions,
 * reset values and step timing.
 * Assumes inclusion by bare name from the watchdog design files.
 */
`ifndef CDW_CONSTS_SVH
`define CDW_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index
`define CDW_IDX_W        8
`define CDW_IDX_IRQ_A    8'h29
`define CDW_IDX_IRQ_B    8'h2A
`define CDW_IDX_WDOG     8'h2D
`define CDW_IDX_FLAGS    8'h2E
`define CDW_IDX_MASK     8'h2F

// Bit positions in the interrupt output enable registers
`define CDW_IEN_BIT      0
`define CDW_IPULSE_BIT   1
// Bit position of the expiry flag in the flag and mask registers
`define CDW_FLAG_BIT     0

// Reset values
`define CDW_CTRL_RST     8'h00
`define CDW_IRQCFG_RST   2'h0

// Oscillator rate and step sizes in microseconds
`define CDW_OSC_HZ       32768
`define CDW_US_PER_S     64'hF4240
`define CDW_STEP_US_00   64'h3D0900
`define CDW_STEP_US_01   64'hF4240
`define CDW_STEP_US_10   64'h3D090
`define CDW_STEP_US_11   64'hF424

// Width of the pulse width configuration input
`define CDW_PW_W         8

`endif

// ==== rtl/cdw_pkg.sv ====
/*
 * Types of the countdown watchdog: control register layout, per-output
 * interrupt configuration and counter states.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package cdw_pkg;

    // Watchdog control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       wdog_repeat_select;  // 1 repeat, 0 single shot
        logic [4:0] wdog_count_field;    // Load value on write, live count on read
        logic [1:0] wdog_step_select;    // Step size select
    } cdw_ctrl_t;

    // Configuration of one interrupt output
    typedef struct packed {
        logic pulse_mode;                // 1 pulse per period end, 0 level
        logic wdog_irq_en;               // Expiry drives this output
    } cdw_irqcfg_t;

    // Counter states, one-hot
    typedef enum logic [1:0] {
        CDW_HALT = 2'h1,
        CDW_RUN  = 2'h2
    } cdw_state_t;

endpackage

// ==== rtl/cdw_tick_gen.sv ====
/*
 * Step tick generator: divides synchronised oscillator edges into the
 * four selectable watchdog step ticks.
 * Assumes osc_rise_in is a one-cycle pulse per oscillator rising edge,
 * already synchronised to clk_in, and OSC_HZ a power of two of 16 or more.
 */
`timescale 1ns/1ps
`include "cdw_consts.svh"

module cdw_tick_gen #(
    parameter int unsigned OSC_HZ = `CDW_OSC_HZ
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       osc_rise_in,
    input  wire logic [1:0] step_sel_in,
    output logic            tick_out
);

    // Oscillator edges per step, derived from the step times
    localparam longint unsigned DIV_00 = (64'(OSC_HZ) * `CDW_STEP_US_00) / `CDW_US_PER_S;
    localparam longint unsigned DIV_01 = (64'(OSC_HZ) * `CDW_STEP_US_01) / `CDW_US_PER_S;
    localparam longint unsigned DIV_10 = (64'(OSC_HZ) * `CDW_STEP_US_10) / `CDW_US_PER_S;
    localparam longint unsigned DIV_11 = (64'(OSC_HZ) * `CDW_STEP_US_11) / `CDW_US_PER_S;
    localparam int unsigned     PRE_W  = $clog2(DIV_00);

    logic [PRE_W-1:0] pre_q;         // Free running oscillator edge count
    logic [PRE_W-1:0] mask;          // Low bits that span one step

    // Step select to edge mask: 00 4 s, 01 1 s, 10 1/4 s, 11 1/16 s
    function automatic logic [PRE_W-1:0] step_mask(input logic [1:0] sel);
        case (sel)
            2'h0:    step_mask = PRE_W'(DIV_00 - 1);  // R1
            2'h1:    step_mask = PRE_W'(DIV_01 - 1);  // R1
            2'h2:    step_mask = PRE_W'(DIV_10 - 1);  // R1
            default: step_mask = PRE_W'(DIV_11 - 1);  // R1
        endcase
    endfunction

    // Prescaler never restarts, so periods after the first are exact
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pre_q <= '0;
        end else if (osc_rise_in) begin
            pre_q <= pre_q + PRE_W'(1);  // R16 R6
        end
    end

    // Tick on the edge that completes a whole step
    always_comb begin
        mask     = step_mask(step_sel_in);
        tick_out = osc_rise_in && ((pre_q & mask) == mask);  // R16
    end

endmodule

// ==== rtl/cdw_wdog_top.sv ====
/*
 * Countdown watchdog with AHB-Lite register slave, oscillator driven step
 * ticks, single shot and repeat modes, sticky expiry flag and two active
 * low interrupt outputs plus one level interrupt.
 * Assumes a single clk_in domain; osc_in is an asynchronous pin; the bus
 * master issues single word transfers.
 */
// Function
// R1: Step select picks 4s, 1s, 1/4s, 1/16s
// R2: Period equals loaded count times step size
// R3: Five bit load value counts down per tick
// R4: Zero count halts, nonzero count starts
// R5: New count replaces running count immediately
// R6: First period may differ by one tick
// R7: Count field reads live counter value
// R8: Software reads count twice for consistency
// R9: Repeat mode flags, reloads, restarts
// R10: Single shot flags, stops at zero
// R11: Expiry flag sticky until software clears
// R12: Per output enables gate expiry interrupts
// R13: Output pulses or follows flag per mode
// R14: Pulse mode pulses every period end
// R15: Reset gives zero count, mode, step
// R16: Ticks divided from oscillator clock
// R17: Count load crosses via handshake
// R18: Active low outputs, configurable pulse width
`timescale 1ns/1ps
`include "cdw_consts.svh"

module cdw_wdog_top #(
    parameter int unsigned OSC_HZ = `CDW_OSC_HZ,  // Oscillator rate
    parameter int unsigned PW_W   = `CDW_PW_W     // Pulse width input width
) (
    input  wire logic            clk_in,
    input  wire logic            rst_in,
    input  wire logic            osc_in,
    input  wire logic [PW_W-1:0] pulse_width_in,
    input  wire logic            hsel_in,
    input  wire logic [31:0]     haddr_in,
    input  wire logic [1:0]      htrans_in,
    input  wire logic            hwrite_in,
    input  wire logic [2:0]      hsize_in,
    input  wire logic [31:0]     hwdata_in,
    input  wire logic            hready_in,
    output logic                 hreadyout_out,
    output logic [31:0]          hrdata_out,
    output logic                 hresp_out,
    output logic                 irq_out_a_n_out,
    output logic                 irq_out_b_n_out,
    output logic                 wdog_irq_out
);

    // Address hit on a register index, word aligned, nothing above
    function automatic logic reg_hit(input logic [31:0] addr,
                                     input logic [`CDW_IDX_W-1:0] idx);
        reg_hit = (addr[31:`CDW_IDX_W+2] == '0) && (addr[`CDW_IDX_W+1:2] == idx)
                  && (addr[1:0] == 2'h0);
    endfunction

    // Reset image of the control register, split by field
    localparam cdw_pkg::cdw_ctrl_t CTRL_RST = `CDW_CTRL_RST;

    // Bus data phase state
    logic                 dp_valid_q;     // A data phase is open
    logic                 dp_write_q;     // It is a write
    logic [31:0]          dp_addr_q;      // Its address
    logic [31:0]          hrdata_q;       // Read data
    logic                 addr_phase;     // Transfer taken this cycle

    // Register state
    logic                 repeat_q;       // Repeat mode
    logic [1:0]           step_q;         // Step select
    cdw_pkg::cdw_irqcfg_t cfg_q [2];      // Per output configuration
    logic                 flag_q;         // Expiry flag
    logic                 flag_d;         // Its next value
    logic                 mask_q;         // Interrupt mask

    // Load handshake toward the tick logic
    logic                 pend_q;         // Load request open
    logic [4:0]           pend_val_q;     // Value to load
    logic                 load_ack;       // Request taken on an oscillator edge

    // Counter
    cdw_pkg::cdw_state_t  state_q;        // Halted or running
    logic [4:0]           cnt_q;          // Live count
    logic [4:0]           reload_q;       // Value reloaded in repeat mode
    logic                 expire;         // Period end this cycle

    // Oscillator synchroniser and edge
    logic                 osc_s1_q;       // First stage
    logic                 osc_s2_q;       // Second stage
    logic                 osc_s3_q;       // Edge history
    logic                 osc_rise;       // One pulse per oscillator edge
    logic                 tick;           // Step tick

    // Write strobes decoded in the data phase
    logic                 wr_ctrl;
    logic                 wr_irq_a;
    logic                 wr_irq_b;
    logic                 wr_flags;
    logic                 wr_mask;
    cdw_pkg::cdw_ctrl_t   wr_word;        // Write data seen as control fields

    // Zero wait state slave, always OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = hrdata_q;
    assign addr_phase    = hsel_in && hready_in && htrans_in[1];
    assign wr_word       = hwdata_in[$bits(cdw_pkg::cdw_ctrl_t)-1:0];

    // Capture the address phase of each transfer
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q  <= 32'h0;
        end else if (hready_in) begin
            dp_valid_q <= addr_phase;
            dp_write_q <= hwrite_in;
            dp_addr_q  <= haddr_in;
        end
    end

    // Read data, sampled at the address phase edge
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            hrdata_q <= 32'h0;
        end else if (addr_phase && !hwrite_in) begin
            if (reg_hit(haddr_in, `CDW_IDX_WDOG)) begin
                hrdata_q <= {24'h0, repeat_q, cnt_q, step_q};  // R7
            end else if (reg_hit(haddr_in, `CDW_IDX_IRQ_A)) begin
                hrdata_q <= {30'h0, cfg_q[0]};
            end else if (reg_hit(haddr_in, `CDW_IDX_IRQ_B)) begin
                hrdata_q <= {30'h0, cfg_q[1]};
            end else if (reg_hit(haddr_in, `CDW_IDX_FLAGS)) begin
                hrdata_q <= {31'h0, flag_q};
            end else if (reg_hit(haddr_in, `CDW_IDX_MASK)) begin
                hrdata_q <= {31'h0, mask_q};
            end else begin
                // Unmapped address reads zero
                hrdata_q <= 32'h0;
            end
        end
    end

    // Write strobes
    always_comb begin
        wr_ctrl  = dp_valid_q && dp_write_q && reg_hit(dp_addr_q, `CDW_IDX_WDOG);
        wr_irq_a = dp_valid_q && dp_write_q && reg_hit(dp_addr_q, `CDW_IDX_IRQ_A);
        wr_irq_b = dp_valid_q && dp_write_q && reg_hit(dp_addr_q, `CDW_IDX_IRQ_B);
        wr_flags = dp_valid_q && dp_write_q && reg_hit(dp_addr_q, `CDW_IDX_FLAGS);
        wr_mask  = dp_valid_q && dp_write_q && reg_hit(dp_addr_q, `CDW_IDX_MASK);
    end

    // Mode and step take effect at once
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            repeat_q <= CTRL_RST.wdog_repeat_select;  // R15
            step_q   <= CTRL_RST.wdog_step_select;    // R15
        end else if (wr_ctrl) begin
            repeat_q <= wr_word.wdog_repeat_select;
            step_q   <= wr_word.wdog_step_select;
        end
    end

    // Interrupt output configuration and mask
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cfg_q[0] <= `CDW_IRQCFG_RST;
            cfg_q[1] <= `CDW_IRQCFG_RST;
            mask_q   <= 1'b0;
        end else begin
            if (wr_irq_a) begin
                cfg_q[0] <= {hwdata_in[`CDW_IPULSE_BIT], hwdata_in[`CDW_IEN_BIT]};  // R12
            end
            if (wr_irq_b) begin
                cfg_q[1] <= {hwdata_in[`CDW_IPULSE_BIT], hwdata_in[`CDW_IEN_BIT]};  // R12
            end
            if (wr_mask) begin
                mask_q <= hwdata_in[`CDW_FLAG_BIT];
            end
        end
    end

    // Oscillator pin through two flip-flops, then edge detect
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= osc_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end
    assign osc_rise = osc_s2_q && !osc_s3_q;

    // Step tick from the oscillator divider
    cdw_tick_gen #(
        .OSC_HZ      (OSC_HZ)
    ) u_tick (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .osc_rise_in (osc_rise),
        .step_sel_in (step_q),
        .tick_out    (tick)
    );

    // Load request, taken by the tick logic on the next oscillator edge
    assign load_ack = pend_q && osc_rise;  // R17
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pend_q     <= 1'b0;
            pend_val_q <= 5'h0;
        end else if (wr_ctrl) begin
            // A write in the acknowledge cycle keeps the request open
            pend_q     <= 1'b1;              // R17
            pend_val_q <= wr_word.wdog_count_field;  // R3
        end else if (load_ack) begin
            pend_q     <= 1'b0;              // R17
        end
    end

    // Period end: last tick of a running count, unless a load overrides
    assign expire = (state_q == cdw_pkg::CDW_RUN) && tick && (cnt_q == 5'h1) && !load_ack;

    // Countdown counter
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q  <= cdw_pkg::CDW_HALT;   // R15
            cnt_q    <= CTRL_RST.wdog_count_field;  // R15
            reload_q <= 5'h0;
        end else if (load_ack) begin
            // A fresh load replaces the running count at once
            cnt_q    <= pend_val_q;          // R5
            reload_q <= pend_val_q;
            state_q  <= (pend_val_q != 5'h0) ? cdw_pkg::CDW_RUN : cdw_pkg::CDW_HALT;  // R4
        end else begin
            case (state_q)
                cdw_pkg::CDW_RUN: begin
                    if (expire && repeat_q) begin
                        cnt_q <= reload_q;   // R9
                    end else if (expire) begin
                        cnt_q   <= 5'h0;     // R10
                        state_q <= cdw_pkg::CDW_HALT;  // R10
                    end else if (tick) begin
                        cnt_q <= cnt_q - 5'h1;  // R2
                    end
                end
                cdw_pkg::CDW_HALT: begin
                    // Stays halted until software loads a count
                    cnt_q <= cnt_q;
                end
                default: begin
                    state_q <= cdw_pkg::CDW_HALT;
                end
            endcase
        end
    end

    // Expiry flag: a period end wins over a clear in the same cycle
    assign flag_d = expire || (flag_q && !(wr_flags && hwdata_in[`CDW_FLAG_BIT]));  // R11
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;                // R11
        end
    end

    // Level interrupt for the host, high while the unmasked flag is set
    assign wdog_irq_out = flag_q && mask_q;

    // Two active low interrupt outputs
    logic [1:0] irq_n_q;                     // Registered output levels
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_irq
            logic [PW_W-1:0] pcnt_q;         // Remaining pulse cycles after the first

            // Pulse length counter, restarted at each period end while the output is enabled in pulse mode
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    pcnt_q <= '0;
                end else if (expire && cfg_q[g].wdog_irq_en && cfg_q[g].pulse_mode) begin
                    // Width zero is taken as one cycle
                    pcnt_q <= (pulse_width_in == '0) ? '0 : pulse_width_in - PW_W'(1);  // R18
                end else if (pcnt_q != '0) begin
                    pcnt_q <= pcnt_q - PW_W'(1);
                end
            end

            // Output level: pulse per period end, or follow the flag
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    irq_n_q[g] <= 1'b1;
                end else if (!cfg_q[g].wdog_irq_en) begin
                    irq_n_q[g] <= 1'b1;          // R12
                end else if (cfg_q[g].pulse_mode) begin
                    irq_n_q[g] <= !(expire || (pcnt_q != '0));  // R14
                end else begin
                    irq_n_q[g] <= !flag_d;       // R13
                end
            end

            a_pulse_on_end: assert property (@(posedge clk_in) disable iff (rst_in) // R14
                (expire && cfg_q[g].wdog_irq_en && cfg_q[g].pulse_mode) |=> !irq_n_q[g])
                else $error("no interrupt pulse at period end");
            a_irq_gated_off: assert property (@(posedge clk_in) disable iff (rst_in) // R12
                !cfg_q[g].wdog_irq_en |=> irq_n_q[g])
                else $error("disabled interrupt output asserted");
            a_level_follows: assert property (@(posedge clk_in) disable iff (rst_in) // R13
                (cfg_q[g].wdog_irq_en && !cfg_q[g].pulse_mode) |=> (irq_n_q[g] == !flag_q))
                else $error("level interrupt does not follow flag");
        end
    endgenerate
    assign irq_out_a_n_out = irq_n_q[0];
    assign irq_out_b_n_out = irq_n_q[1];

    // Checks on counter, load and flag behaviour
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_load_zero;
        load_ack && (pend_val_q == 5'h0);
    endsequence
    sequence s_end_single;
        expire && !repeat_q;
    endsequence
    sequence s_end_repeat;
        expire && repeat_q;
    endsequence

    a_halt_on_zero: assert property ( // R4
        s_load_zero |=> (state_q == cdw_pkg::CDW_HALT) && (cnt_q == 5'h0)
                        ##1 (cnt_q == 5'h0))
        else $error("zero load did not halt the counter");
    a_load_replaces: assert property ( // R5
        load_ack |=> (cnt_q == $past(pend_val_q)) && (reload_q == $past(pend_val_q)))
        else $error("load did not replace the running count");
    a_repeat_reload: assert property ( // R9
        s_end_repeat |=> (cnt_q == reload_q) && (state_q == cdw_pkg::CDW_RUN) && flag_q)
        else $error("repeat mode did not reload");
    a_single_stops: assert property ( // R10
        s_end_single |=> (state_q == cdw_pkg::CDW_HALT) && (cnt_q == 5'h0) && flag_q)
        else $error("single shot did not stop at zero");
    a_flag_sticky: assert property ( // R11
        (flag_q && !(wr_flags && hwdata_in[`CDW_FLAG_BIT])) |=> flag_q)
        else $error("expiry flag dropped without clear");
    a_tick_decrement: assert property ( // R2
        (tick && state_q == cdw_pkg::CDW_RUN && cnt_q > 5'h1 && !load_ack)
        |=> (cnt_q == $past(cnt_q) - 5'h1))
        else $error("count did not step down on tick");
    a_count_holds: assert property ( // R3
        (!tick && !load_ack) |=> $stable(cnt_q))
        else $error("count moved without a tick");
    a_load_on_osc: assert property ( // R17
        (pend_q && !osc_rise && !wr_ctrl) |=> pend_q && $stable(cnt_q))
        else $error("load crossed without oscillator edge");

endmodule

// ==== verif/tb.sv ====
/*
 * Self-checking bench for the countdown watchdog: bus tasks, period timing,
 * live count, sticky flag and interrupt output checks.
 * Assumes the watchdog top, its package and the constants header.
 */
`timescale 1ns/1ps
`include "cdw_consts.svh"

module tb;
    localparam int OSC   = 64;     // Shrunk oscillator rate
    localparam int OCLK  = 8;      // Clock cycles per oscillator period
    localparam int PW    = 3;      // Pulse width in clock cycles
    localparam int LIMIT = 60000;  // Cycle ceiling of the run
    // Byte addresses of the registers
    localparam logic [31:0] A_IRQA = {22'h0, `CDW_IDX_IRQ_A, 2'h0};
    localparam logic [31:0] A_IRQB = {22'h0, `CDW_IDX_IRQ_B, 2'h0};
    localparam logic [31:0] A_CTRL = {22'h0, `CDW_IDX_WDOG, 2'h0};
    localparam logic [31:0] A_FLAG = {22'h0, `CDW_IDX_FLAGS, 2'h0};
    localparam logic [31:0] A_MASK = {22'h0, `CDW_IDX_MASK, 2'h0};

    logic        clk_in, rst_in, osc_in, hsel_in, hwrite_in, b_q;     // Bit-wide drives and output B sample
    logic        hreadyout_out, hresp_out, wdog_irq_out;              // Bit-wide outputs
    logic        irq_out_a_n_out, irq_out_b_n_out;                    // Interrupt pins
    logic [7:0]  pulse_width_in;                                      // Pulse width input
    logic [1:0]  htrans_in;                                           // Transfer type
    logic [2:0]  hsize_in;                                            // Transfer size
    logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;                 // Bus words
    int          errors, cmp_count, cyc, pcount, last_fall, prev_fall; // Counters
    int          low_len, last_w, wcnt, p, s;                         // Measurements

    cdw_wdog_top #(.OSC_HZ(OSC), .PW_W(8)) cdw_wdog_top_i (
        .clk_in(clk_in), .rst_in(rst_in), .osc_in(osc_in), .pulse_width_in(pulse_width_in),
        .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
        .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hreadyout_out(hreadyout_out), .hrdata_out(hrdata_out), .hresp_out(hresp_out),
        .irq_out_a_n_out(irq_out_a_n_out), .irq_out_b_n_out(irq_out_b_n_out),
        .wdog_irq_out(wdog_irq_out));

    // System clock, 100 MHz
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Oscillator, OCLK clock cycles a period, toggling on falling clock edges
    initial begin
        osc_in = 1'b0;
        forever #(OCLK*5) osc_in = ~osc_in;
    end

    // Cycle count and timeout; a hang counts as a mismatch
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            errors = errors + 1;
            report_and_stop();
        end
    end

    // Pulse edge times and pulse width of output B
    always @(posedge clk_in) begin
        b_q <= irq_out_b_n_out;
        if (b_q === 1'b1 && irq_out_b_n_out === 1'b0) begin
            pcount    <= pcount + 1;
            prev_fall <= last_fall;
            last_fall <= cyc;
        end
        low_len <= (irq_out_b_n_out === 1'b0) ? low_len + 1 : 0;
        if (b_q === 1'b0 && irq_out_b_n_out === 1'b1) last_w <= low_len;
    end

    // Compare one value and count it
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One bus transfer: address phase, then data phase; read data taken at its end
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_in);
        hsel_in   <= 1'b1;
        haddr_in  <= a;
        htrans_in <= 2'h2;
        hwrite_in <= wr;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        htrans_in <= 2'h0;
        hwdata_in <= d;
        do @(posedge clk_in); while (hreadyout_out !== 1'b1);
        rd = hrdata_out;
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic bus_rd(input logic [31:0] a);
        xfer(1'b0, a, 32'h0);
    endtask

    // Wait for the level interrupt under a bound, cycles kept in wcnt
    task automatic wait_flag(input int max);
        wcnt = 0;
        while (wdog_irq_out !== 1'b1 && wcnt < max) begin
            @(posedge clk_in);
            wcnt = wcnt + 1;
        end
        chk("irq level", 32'h1, {31'h0, wdog_irq_out});
    endtask

    // Wait for n more pulses on output B
    task automatic wait_pulses(input int n);
        int t;
        t = pcount + n;
        while (pcount < t) @(posedge clk_in);
    endtask

    // Step length in clock cycles for a step select value
    function automatic int step(input int sel);
        return (sel == 0 ? OSC*4 : sel == 1 ? OSC : sel == 2 ? OSC/4 : OSC/16) * OCLK;
    endfunction

    // Counts and verdict, then end
    task automatic report_and_stop();
        $display("checks %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        {rst_in, hsel_in, hwrite_in, htrans_in} = 5'h10;  // Counters start at zero as ints
        {haddr_in, hwdata_in, rd} = 96'h0;
        hsize_in       = 3'h2;
        pulse_width_in = 8'(PW);
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        // Reset state of registers and pins
        chk("irq a idle", 32'h1, {31'h0, irq_out_a_n_out});
        bus_rd(A_CTRL); chk("ctrl reset", `CDW_CTRL_RST, rd);
        bus_rd(A_IRQA); chk("irq a cfg", 32'h0, rd);
        bus_rd(32'h100); chk("unmapped", 32'h0, rd);
        chk("hresp okay", 32'h0, {31'h0, hresp_out});
        // A level, B pulse, mask open
        bus_wr(A_IRQA, 32'h1);
        bus_wr(A_IRQB, 32'h3);
        bus_wr(A_MASK, 32'h1);
        // Single shot, count 2, sixteenth second step
        bus_wr(A_CTRL, 32'h0B);
        wait_flag(2*step(3) + OCLK + 8);
        chk("first period", 32'h1, {31'h0, wcnt >= step(3)});
        chk("irq a level", 32'h0, {31'h0, irq_out_a_n_out});
        repeat (PW + 4) @(posedge clk_in);
        chk("pulses", 32'h1, pcount);
        chk("pulse width", PW, last_w);
        bus_rd(A_CTRL); chk("single stop", 32'h03, rd);
        repeat (100) @(posedge clk_in);
        bus_rd(A_FLAG); chk("sticky", 32'h1, rd);
        bus_wr(A_FLAG, 32'h1);
        bus_rd(A_FLAG); chk("cleared", 32'h0, rd);
        chk("irq a off", 32'h1, {31'h0, irq_out_a_n_out});
        // Repeat mode, every step size, flag left set
        for (s = 3; s >= 0; s--) begin
            bus_wr(A_CTRL, 32'h88 | s);
            wait_pulses(3);
            chk("period", 2*step(s), last_fall - prev_fall);
        end
        // Live count one tick into a period of three
        bus_wr(A_CTRL, 32'h8F);
        wait_pulses(3);
        repeat (38) @(posedge clk_in);
        bus_rd(A_CTRL); chk("live count", 32'h8B, rd);
        bus_rd(A_CTRL); chk("second read", 32'h8B, rd);
        // Long count replaced at once by a short one
        bus_wr(A_CTRL, 32'h7C);
        repeat (20) @(posedge clk_in);
        bus_wr(A_FLAG, 32'h1);
        bus_wr(A_CTRL, 32'h07);
        wait_flag(step(3) + OCLK + 8);
        // Zero count halts a running repeat period
        bus_wr(A_CTRL, 32'h87);
        wait_pulses(1);
        repeat (PW + 4) @(posedge clk_in);
        p = pcount;
        bus_wr(A_FLAG, 32'h1);
        bus_wr(A_CTRL, 32'h83);
        repeat (300) @(posedge clk_in);
        chk("halt pulses", p, pcount);
        chk("halt flag", 32'h0, {31'h0, wdog_irq_out});
        bus_rd(A_CTRL); chk("halt count", 32'h83, rd);
        // Outputs disabled and mask closed while the flag sets
        bus_wr(A_IRQA, 32'h0);
        bus_wr(A_IRQB, 32'h2);
        bus_wr(A_MASK, 32'h0);
        p = pcount;
        bus_wr(A_CTRL, 32'h87);
        repeat (200) @(posedge clk_in);
        chk("b gated", p, pcount);
        chk("a gated", 32'h1, {31'h0, irq_out_a_n_out});
        chk("masked", 32'h0, {31'h0, wdog_irq_out});
        bus_rd(A_FLAG); chk("flag set", 32'h1, rd);
        report_and_stop();
    end
endmodule
